// file: design/ibsf_cond_det.sv
`timescale 1ns/1ps
// ************************************************************
// start and stop condition detector on synchronised pins
// ************************************************************
module ibsf_cond_det
    import ibsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic scl_sync,
    input wire logic sda_sync,
    output ibsf_cond_type cond_ff
);
    logic scl_prev_ff; // clock level one sample ago
    logic sda_prev_ff; // data level one sample ago
    ibsf_cond_type nxt_cond;

    // data edge while clock stays high marks a condition
    always_comb begin
        nxt_cond.start = scl_prev_ff && scl_sync && sda_prev_ff && !sda_sync;
        nxt_cond.stop = scl_prev_ff && scl_sync && !sda_prev_ff && sda_sync;
    end

    // history and registered one cycle pulses
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            scl_prev_ff <= 1'b1;
            sda_prev_ff <= 1'b1;
            cond_ff <= '0;
        end else begin
            scl_prev_ff <= scl_sync;
            sda_prev_ff <= sda_sync;
            cond_ff <= nxt_cond;
        end
    end
endmodule

// file: design/ibsf_sync.sv
`timescale 1ns/1ps
// ************************************************************
// two flop synchroniser for pin levels
// ************************************************************
module ibsf_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff; // first stage, read only by the second

    // idle bus level is high, so both stages reset high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= '1;
            sync_out <= '1;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule

// file: design/ibsf_top.sv
`timescale 1ns/1ps
// What this block does
// - status bit 15 reads zero, writes ignored
// - set slave direction when addressed as transmitter
// - writing one clears slave direction flag
// - loopback enabled clears slave direction flag
// - start or stop on bus clears direction
// - set nack sent when receiver drives nack
// - nack next byte command also sets nack sent
// - nack sent cleared by w1c, run off, reset
// - bus busy flag shows bus occupied or free
// - stop or module reset clears bus busy
// - start received or sent sets bus busy
// - writing zero to w1c flag changes nothing
module ibsf_top
    import ibsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    output logic [DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // two-wire bus pins, sampled only
    input wire logic scl_in,
    input wire logic sda_in,
    // events from the controller engine, same clock
    input wire logic own_start_sent,
    input wire logic own_stop_sent,
    input wire logic slave_tx_addressed,
    input wire logic rx_ack_slot,
    input wire logic rx_nack_req,
    // results
    output logic ack_nack,
    output logic bus_busy,
    output logic irq
);

    // ************************************************************
    // pin synchronisation and condition detection
    // ************************************************************
    logic [1:0] pin_sync; // {scl, sda} after two flops
    ibsf_cond_type bus_cond; // one cycle pulses from the pins

    ibsf_sync #(
        .WIDTH(2)
    ) u_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .async_in({scl_in, sda_in}),
        .sync_out(pin_sync)
    );

    ibsf_cond_det u_cond (
        .core_clk(core_clk),
        .rstn(rstn),
        .scl_sync(pin_sync[1]),
        .sda_sync(pin_sync[0]),
        .cond_ff(bus_cond)
    );

    // ************************************************************
    // register state
    // ************************************************************
    logic [CTRL_W-1:0] ctrl_ff; // run, loopback, nack next
    logic [EVT_W-1:0] irq_mask_ff; // interrupt mask
    logic [EVT_W-1:0] irq_stat_ff; // sticky interrupt events
    logic slave_tx_direction_flag_ff; // slave_tx_direction_flag
    logic nack_sent_ff; // nack_sent_flag
    logic bus_busy_ff; // bus_busy_flag
    logic ack_nack_ff; // nack answer pulse to the shifter
    logic irq_ff; // registered interrupt level
    logic waitreq_ff; // avalon waitrequest
    logic [DATA_W-1:0] rdata_ff; // avalon read data

    // ************************************************************
    // bus decode
    // ************************************************************
    logic req; // read or write pending
    logic wr_go; // write completes this edge
    logic [DATA_W-1:0] wmask; // lanes enabled by byteenable
    logic [DATA_W-1:0] w1; // enabled ones of the write data
    logic sel_stat; // address hits bus_status
    logic sel_ctrl; // address hits control
    logic sel_mask; // address hits interrupt mask
    logic sel_istat; // address hits interrupt status

    assign req = avs_read || avs_write;
    assign wr_go = avs_write && !waitreq_ff;
    assign wmask = ibsf_lane_mask(avs_byteenable);
    assign w1 = avs_writedata & wmask;
    assign sel_stat = (avs_address == OFS_BUS_STATUS);
    assign sel_ctrl = (avs_address == OFS_CONTROL);
    assign sel_mask = (avs_address == OFS_IRQ_MASK);
    assign sel_istat = (avs_address == OFS_IRQ_STATUS);

    // ************************************************************
    // event sources
    // ************************************************************
    logic mod_rst; // module held in reset while run is off
    logic loop_on; // digital loopback enabled
    logic start_ev; // start seen on the bus or sent by us
    logic stop_ev; // stop seen on the bus or sent by us
    logic nack_ev; // we answer this ack slot with nack
    logic slave_tx_direction_flag_w1c; // software clears slave direction
    logic nack_w1c; // software clears nack sent
    ibsf_evt_type evt; // events feeding the sticky status

    assign mod_rst = !ctrl_ff[CTRL_RUN_BIT];
    assign loop_on = ctrl_ff[CTRL_LOOP_BIT];
    // own conditions also show on the pins; the or covers loopback,
    // where the pins are not driven by us
    assign start_ev = bus_cond.start || own_start_sent;
    assign stop_ev = bus_cond.stop || own_stop_sent;
    // receiver ack slot answered nack by the engine or by the command
    assign nack_ev = rx_ack_slot && (rx_nack_req || ctrl_ff[CTRL_NACKNXT_BIT]);
    // only a written one clears; a zero or a disabled lane is ignored
    assign slave_tx_direction_flag_w1c = wr_go && sel_stat && w1[STAT_SLAVE_TX_DIRECTION_FLAG_BIT];
    assign nack_w1c = wr_go && sel_stat && w1[STAT_NACK_BIT];

    always_comb begin
        evt.start = start_ev && !mod_rst;
        evt.stop = stop_ev && !mod_rst;
        evt.slave_tx = slave_tx_addressed && !mod_rst;
        evt.nack_sent = nack_ev && !mod_rst;
    end

    // ************************************************************
    // avalon handshake
    // ************************************************************
    // waitrequest drops for one cycle after a request is seen, so
    // every access completes on the second edge of its request
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            waitreq_ff <= 1'b1;
        end else begin
            waitreq_ff <= !(req && waitreq_ff);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    logic [DATA_W-1:0] nxt_rdata;
    logic [STAT_W-1:0] stat_view;

    // bit 15 and the lower half are always zero here
    always_comb begin
        stat_view = STAT_RST;
        stat_view[STAT_RSVD_BIT] = 1'b0;
        stat_view[STAT_SLAVE_TX_DIRECTION_FLAG_BIT] = slave_tx_direction_flag_ff;
        stat_view[STAT_NACK_BIT] = nack_sent_ff;
        stat_view[STAT_BB_BIT] = bus_busy_ff;
    end

    // unmapped addresses read zero
    always_comb begin
        nxt_rdata = '0;
        if (sel_stat) begin
            nxt_rdata[STAT_W-1:0] = stat_view;
        end else if (sel_ctrl) begin
            nxt_rdata[CTRL_W-1:0] = ctrl_ff;
        end else if (sel_mask) begin
            nxt_rdata[EVT_W-1:0] = irq_mask_ff;
        end else if (sel_istat) begin
            nxt_rdata[EVT_W-1:0] = irq_stat_ff;
        end
    end

    // loaded in the cycle waitrequest is high, so it stands at the
    // completing edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= '0;
        end else if (avs_read && waitreq_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    // the nack command is spent by one ack slot; a software write in
    // the same cycle wins so a fresh command is not dropped
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_ff <= CTRL_RST;
        end else if (wr_go && sel_ctrl && avs_byteenable[0]) begin
            ctrl_ff <= avs_writedata[CTRL_W-1:0];
        end else if (nack_ev) begin
            ctrl_ff[CTRL_NACKNXT_BIT] <= 1'b0;
        end
    end

    // ************************************************************
    // interrupt mask
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_mask_ff <= EVT_RST;
        end else if (wr_go && sel_mask && avs_byteenable[0]) begin
            irq_mask_ff <= avs_writedata[EVT_W-1:0];
        end
    end

    // ************************************************************
    // sticky interrupt status
    // ************************************************************
    // set term is or-ed after the clear so an event is never lost
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_ff <= EVT_RST;
        end else if (wr_go && sel_istat) begin
            irq_stat_ff <= (irq_stat_ff & ~w1[EVT_W-1:0]) | evt;
        end else begin
            irq_stat_ff <= irq_stat_ff | evt;
        end
    end

    // level output, one cycle behind the status
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // ************************************************************
    // slave direction flag
    // ************************************************************
    // addressing always follows its start by many cycles, so the set
    // taking priority costs nothing and keeps a same cycle w1c safe
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slave_tx_direction_flag_ff <= 1'b0;
        end else if (mod_rst) begin
            slave_tx_direction_flag_ff <= 1'b0;
        end else if (slave_tx_addressed) begin
            slave_tx_direction_flag_ff <= 1'b1;
        end else if (loop_on) begin
            slave_tx_direction_flag_ff <= 1'b0;
        end else if (start_ev || stop_ev) begin
            slave_tx_direction_flag_ff <= 1'b0;
        end else if (slave_tx_direction_flag_w1c) begin
            slave_tx_direction_flag_ff <= 1'b0;
        end
    end

    // ************************************************************
    // nack sent flag
    // ************************************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            nack_sent_ff <= 1'b0;
        end else if (mod_rst) begin
            nack_sent_ff <= 1'b0;
        end else if (nack_ev) begin
            nack_sent_ff <= 1'b1;
        end else if (nack_w1c) begin
            nack_sent_ff <= 1'b0;
        end
    end

    // nack answer pulse for the data shifter
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ack_nack_ff <= 1'b0;
        end else begin
            ack_nack_ff <= nack_ev && !mod_rst;
        end
    end

    // ************************************************************
    // bus busy flag
    // ************************************************************
    // read only: bus_status writes never touch it; a start and a stop
    // in one cycle cannot occur, start is checked first anyway
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bus_busy_ff <= 1'b0;
        end else if (mod_rst) begin
            bus_busy_ff <= 1'b0;
        end else if (start_ev) begin
            bus_busy_ff <= 1'b1;
        end else if (stop_ev) begin
            bus_busy_ff <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign avs_readdata = rdata_ff;
    assign avs_waitrequest = waitreq_ff;
    assign ack_nack = ack_nack_ff;
    assign bus_busy = bus_busy_ff;
    assign irq = irq_ff;

endmodule

// file: include/ibsf_pkg.sv
package ibsf_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 4;             // byte address, word aligned
    localparam int DATA_W = 32;            // avalon data width
    localparam int BE_W = 4;               // byte enables

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFS_BUS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'hc;

    // ************************************************************
    // bus_status layout
    // ************************************************************
    localparam int STAT_W = 16;
    localparam int STAT_RSVD_BIT = 15;     // always zero
    localparam int STAT_SLAVE_TX_DIRECTION_FLAG_BIT = 14;     // slave_tx_direction_flag
    localparam int STAT_NACK_BIT = 13;     // nack_sent_flag
    localparam int STAT_BB_BIT = 12;       // bus_busy_flag
    localparam logic [STAT_W-1:0] STAT_RST = 16'h0000;

    // ************************************************************
    // control layout
    // ************************************************************
    localparam int CTRL_W = 3;
    localparam int CTRL_RUN_BIT = 0;       // module_run_enable
    localparam int CTRL_LOOP_BIT = 1;      // digital loopback on
    localparam int CTRL_NACKNXT_BIT = 2;   // nack_next_byte_control
    localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

    // ************************************************************
    // interrupt status and mask layout
    // ************************************************************
    localparam int EVT_W = 4;
    localparam int EVT_START_BIT = 0;
    localparam int EVT_STOP_BIT = 1;
    localparam int EVT_SLAVE_TX_DIRECTION_FLAG_BIT = 2;
    localparam int EVT_NACK_BIT = 3;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic stop;
        logic start;
    } ibsf_cond_type;

    typedef struct packed {
        logic nack_sent;
        logic slave_tx;
        logic stop;
        logic start;
    } ibsf_evt_type;

    // expand byte enables into a bit mask over the data word
    function automatic logic [DATA_W-1:0] ibsf_lane_mask(input logic [BE_W-1:0] be);
        logic [DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < BE_W; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

endpackage

// file: verif/ibsf_bus_model.sv
`timescale 1ns/1ps
// ************************************************************
// another master on the two-wire bus, open drain with pull-ups
// ************************************************************
module ibsf_bus_model (
    input wire logic core_clk,
    output logic scl,
    output logic sda
);
    localparam int HALF = 4; // 4 core cycles = half of a 200 ns link period
    logic scl_low_ff; // model pulls the clock line low
    logic sda_low_ff; // model pulls the data line low
    initial begin
        scl_low_ff = 1'b0;
        sda_low_ff = 1'b0;
    end
    // released lines float up to the pull-up level; clock is left low after start and byte frames, high after stop
    assign scl = !scl_low_ff;
    assign sda = !sda_low_ff;
    task automatic hold();
        repeat (HALF) @(posedge core_clk);
    endtask
    // data falls while clock high
    task automatic frame_start();
        sda_low_ff <= 1'b1;
        hold();
        scl_low_ff <= 1'b1;
        hold();
    endtask
    // data changes only while clock low, so no false start or stop
    task automatic frame_byte(input logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            sda_low_ff <= (i >= 0) ? !b[i] : 1'b0;
            hold();
            scl_low_ff <= 1'b0;
            hold();
            scl_low_ff <= 1'b1;
        end
    endtask
    // data rises while clock high
    task automatic frame_stop();
        sda_low_ff <= 1'b1;
        hold();
        scl_low_ff <= 1'b0;
        hold();
        sda_low_ff <= 1'b0;
    endtask
endmodule

// file: verif/ibsf_monitor.sv
`timescale 1ns/1ps
// ************************************************************
// port level checker for the status flag block
// ************************************************************
module ibsf_monitor
    import ibsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [DATA_W-1:0] avs_writedata,
    input wire logic [BE_W-1:0] avs_byteenable,
    input wire logic [DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic own_start_sent,
    input wire logic own_stop_sent,
    input wire logic slave_tx_addressed,
    input wire logic rx_ack_slot,
    input wire logic rx_nack_req,
    input wire logic ack_nack,
    input wire logic bus_busy,
    input wire logic irq
);
    logic run_ff; // shadow of the run enable bit
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // shadow taken at the completing edge, so flags are only expected while running
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 1'b0;
        end else if (avs_write && !avs_waitrequest && avs_address == OFS_CONTROL && avs_byteenable[0]) begin
            run_ff <= avs_writedata[CTRL_RUN_BIT];
        end
    end
    property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest; endproperty
    property p_rd_zero; avs_read && !avs_waitrequest && avs_address == OFS_BUS_STATUS
        |-> avs_readdata[31:15] == 17'h0 && avs_readdata[11:0] == 12'h0; endproperty
    property p_own_start; run_ff && own_start_sent && !own_stop_sent |=> bus_busy; endproperty
    property p_own_stop; own_stop_sent && !own_start_sent |=> !bus_busy; endproperty
    property p_run_off; !run_ff |=> !bus_busy; endproperty
    property p_pin_start; run_ff && scl_in && $fell(sda_in) |-> ##[1:6] bus_busy; endproperty
    property p_pin_stop; scl_in && $rose(sda_in) |-> ##[1:6] !bus_busy; endproperty
    property p_nack; run_ff && rx_ack_slot && rx_nack_req |=> ack_nack; endproperty
    property p_nack_cause; !rx_ack_slot |=> !ack_nack; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not low for exactly one cycle");
    a_rd_zero: assert property (p_rd_zero) else $error("unused status bits read nonzero");
    a_own_start: assert property (p_own_start) else $error("start sent did not set busy");
    a_own_stop: assert property (p_own_stop) else $error("stop sent did not clear busy");
    a_run_off: assert property (p_run_off) else $error("busy set while module held off");
    a_pin_start: assert property (p_pin_start) else $error("start on pins did not set busy");
    a_pin_stop: assert property (p_pin_stop) else $error("stop on pins did not clear busy");
    a_nack: assert property (p_nack) else $error("nack answer missing");
    a_nack_cause: assert property (p_nack_cause) else $error("nack answer without ack slot");
    c_busy: cover property (run_ff && $rose(bus_busy));
    c_nack: cover property (ack_nack);
    c_status_rd: cover property (avs_read && !avs_waitrequest && avs_address == OFS_BUS_STATUS);
endmodule

bind ibsf_top ibsf_monitor ibsf_monitor_inst (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .sda_in(sda_in),
    .own_start_sent(own_start_sent), .own_stop_sent(own_stop_sent), .slave_tx_addressed(slave_tx_addressed),
    .rx_ack_slot(rx_ack_slot), .rx_nack_req(rx_nack_req), .ack_nack(ack_nack), .bus_busy(bus_busy), .irq(irq));

// file: verif/ibsf_top_bench.sv
`timescale 1ns/1ps
module ibsf_top_bench;
    import ibsf_pkg::*;
    // ************************************************************
    // signals
    // ************************************************************
    logic core_clk, rstn, avs_read, avs_write, avs_waitrequest;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, scratch;
    logic [BE_W-1:0] avs_byteenable;
    logic own_start_sent, own_stop_sent, slave_tx_addressed, rx_ack_slot, rx_nack_req;
    logic ack_nack, bus_busy, irq;
    wire scl_in, sda_in;
    int failures = 0;
    int n_checks = 0;
    ibsf_top ibsf_top_inst (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_in(scl_in), .sda_in(sda_in),
        .own_start_sent(own_start_sent), .own_stop_sent(own_stop_sent), .slave_tx_addressed(slave_tx_addressed),
        .rx_ack_slot(rx_ack_slot), .rx_nack_req(rx_nack_req), .ack_nack(ack_nack), .bus_busy(bus_busy), .irq(irq));
    ibsf_bus_model ibsf_bus_model_inst (.core_clk(core_clk), .scl(scl_in), .sda(sda_in));
    // 40 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = !core_clk;
    end
    // ************************************************************
    // helpers
    // ************************************************************
    task automatic chk_word(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask
    // one avalon access; request held until waitrequest is sampled low
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        input logic [BE_W-1:0] be, output logic [DATA_W-1:0] q);
        @(posedge core_clk);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        // no cycle count assumed; a hang is left to the watchdog
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        xfer(1'b1, a, d, 4'hf, scratch);
    endtask
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] q;
        xfer(1'b0, a, 32'h0, 4'hf, q);
        chk_word(what, exp, q);
    endtask
    // one-cycle engine pulse: {start, stop, slave tx, ack slot, nack req}; returns once its effect shows
    task automatic ev(input logic [4:0] v);
        @(posedge core_clk);
        {own_start_sent, own_stop_sent, slave_tx_addressed, rx_ack_slot, rx_nack_req} <= v;
        @(posedge core_clk);
        {own_start_sent, own_stop_sent, slave_tx_addressed, rx_ack_slot, rx_nack_req} <= 5'h0;
        @(posedge core_clk);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        test_done();
    end
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        {own_start_sent, own_stop_sent, slave_tx_addressed, rx_ack_slot, rx_nack_req} = 5'h0;
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        rd_chk("status", OFS_BUS_STATUS, 32'h0);
        ev(5'h10); // start ignored while module held off
        chk_bit("busy", 1'b0, bus_busy);
        xfer(1'b1, OFS_CONTROL, 32'h1, 4'h1, scratch);
        reg_wr(OFS_IRQ_MASK, 32'h0);
        ev(5'h10);
        chk_bit("busy", 1'b1, bus_busy);
        chk_bit("irq", 1'b0, irq);
        rd_chk("irq status", OFS_IRQ_STATUS, 32'h1);
        reg_wr(OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge core_clk);
        chk_bit("irq", 1'b1, irq);
        reg_wr(OFS_IRQ_STATUS, 32'hf);
        repeat (2) @(posedge core_clk);
        chk_bit("irq", 1'b0, irq);
        reg_wr(OFS_BUS_STATUS, 32'h1000); // busy is read only
        rd_chk("status", OFS_BUS_STATUS, 32'h1000);
        ev(5'h08);
        chk_bit("busy", 1'b0, bus_busy);
        ibsf_bus_model_inst.frame_start();
        repeat (2) @(posedge core_clk);
        chk_bit("busy", 1'b1, bus_busy);
        ibsf_bus_model_inst.frame_byte(8'ha5);
        ev(5'h04);
        rd_chk("status", OFS_BUS_STATUS, 32'h5000);
        rd_chk("unmapped", 4'h2, 32'h0);
        reg_wr(OFS_BUS_STATUS, 32'h0);
        rd_chk("status", OFS_BUS_STATUS, 32'h5000);
        reg_wr(OFS_BUS_STATUS, 32'h9000);
        rd_chk("status", OFS_BUS_STATUS, 32'h5000);
        reg_wr(OFS_BUS_STATUS, 32'h4000);
        rd_chk("status", OFS_BUS_STATUS, 32'h1000);
        ev(5'h04);
        ibsf_bus_model_inst.frame_stop();
        repeat (6) @(posedge core_clk);
        rd_chk("status", OFS_BUS_STATUS, 32'h0);
        ev(5'h04);
        ev(5'h10);
        rd_chk("status", OFS_BUS_STATUS, 32'h1000);
        ev(5'h08);
        ev(5'h04);
        reg_wr(OFS_CONTROL, 32'h3);
        rd_chk("status", OFS_BUS_STATUS, 32'h0);
        reg_wr(OFS_CONTROL, 32'h1);
        ev(5'h03);
        chk_bit("nack answer", 1'b1, ack_nack);
        rd_chk("status", OFS_BUS_STATUS, 32'h2000);
        reg_wr(OFS_BUS_STATUS, 32'h2000);
        rd_chk("status", OFS_BUS_STATUS, 32'h0);
        ev(5'h02);
        chk_bit("nack answer", 1'b0, ack_nack);
        reg_wr(OFS_CONTROL, 32'h5);
        ev(5'h02);
        chk_bit("nack answer", 1'b1, ack_nack);
        rd_chk("status", OFS_BUS_STATUS, 32'h2000);
        reg_wr(OFS_CONTROL, 32'h0);
        rd_chk("status", OFS_BUS_STATUS, 32'h0);
        reg_wr(OFS_CONTROL, 32'h1);
        ev(5'h04);
        // slave tx pulse lands on the very edge that completes the clearing write
        fork
            reg_wr(OFS_BUS_STATUS, 32'h4000);
            begin
                @(posedge core_clk);
                ev(5'h04);
            end
        join
        rd_chk("status", OFS_BUS_STATUS, 32'h4000);
        test_done();
    end
endmodule
